//--- mcrb_bank.sv
// modem command and status register bank with the modem state sequencer
// assumes cpu data memory strobes on clk; cca_idle and rf_locked are pins
module mcrb_bank (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        mem_wr_en,
    input  wire logic        mem_rd_en,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    input  wire logic        cca_idle,
    input  wire logic        rf_locked,
    input  wire logic        rx_start_evt,
    input  wire logic        rx_end_evt,
    input  wire logic        tx_done,
    output logic             rf_power_en,
    output logic             modem_rst_n,
    output logic             rx_ready,
    output logic             tx_active,
    output logic             tx_abort,
    output logic             modem_irq
);

    typedef struct packed {
        mcrb_pkg::mcrb_state_t              st;
        logic [7:0]                         cmd0;
        logic [mcrb_pkg::NGEN-1:0][7:0]     gen;
        logic [mcrb_pkg::NIRQ-1:0]          pend_n;
        logic [7:0]                         irq_en;
        logic [7:0]                         cnt;
        logic [7:0]                         rdata;
        logic                               cca_m;
        logic                               cca_s;
        logic                               lock_m;
        logic                               lock_s;
        logic                               abort;
        logic                               irq;
    } mcrb_regs_t;

    function automatic logic [mcrb_pkg::NGEN-1:0][7:0] gen_reset_f();
        logic [mcrb_pkg::NGEN-1:0][7:0] r;
        r = '0;
        for (int i = 0; i < mcrb_pkg::NGEN; i++) begin
            r[i] = mcrb_pkg::GEN_TAB[i].rst;
        end
        return r;
    endfunction : gen_reset_f

    localparam mcrb_regs_t RST_S = '{
        st:     mcrb_pkg::ST_OFF,
        cmd0:   mcrb_pkg::RST_CMD0,
        gen:    gen_reset_f(),
        pend_n: mcrb_pkg::RST_IRQ_PEND[mcrb_pkg::NIRQ-1:0],
        irq_en: mcrb_pkg::RST_IRQ_EN,
        cnt:    8'h00,
        rdata:  8'h00,
        cca_m:  1'b0,
        cca_s:  1'b0,
        lock_m: 1'b0,
        lock_s: 1'b0,
        abort:  1'b0,
        irq:    1'b0
    };

    // {hit, index} of a plain read/write register
    function automatic logic [6:0] gen_find_f(input logic [15:0] a);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < mcrb_pkg::NGEN; i++) begin
            if (mcrb_pkg::GEN_TAB[i].addr == a) begin
                r = {1'b1, 6'(i)};
            end
        end
        return r;
    endfunction : gen_find_f

    // fixed priority, rx end first; disabled sources are skipped
    function automatic logic [7:0] index_f(
        input logic [mcrb_pkg::NIRQ-1:0] pend_n,
        input logic [7:0]                en
    );
        logic [7:0] r;
        logic [mcrb_pkg::NIRQ-1:0] act;
        act = ~pend_n & ~en[mcrb_pkg::NIRQ-1:0];
        r = {1'b1, mcrb_pkg::IDX_FILL, 2'h0};
        for (int i = mcrb_pkg::NIRQ - 1; i >= 0; i--) begin
            if (act[i]) begin
                r = {1'b0, mcrb_pkg::IDX_FILL, 2'(i)};
            end
        end
        return r;
    endfunction : index_f

    mcrb_regs_t s_q;
    mcrb_regs_t s_d;
    logic [mcrb_pkg::NIRQ-1:0] ev;
    logic [6:0] wr_hit;
    logic [6:0] rd_hit;
    logic       wr_cmd0;
    logic       rd_clr;
    logic       tx_busy;
    logic [7:0] st0;
    logic [7:0] st1;

    always_comb begin
        st0 = '0;
        st0[mcrb_pkg::S0_OFF]   = (s_q.st == mcrb_pkg::ST_OFF);
        st0[mcrb_pkg::S0_READY] = (s_q.st == mcrb_pkg::ST_READY);
        st0[mcrb_pkg::S0_TXDLY] = (s_q.st == mcrb_pkg::ST_TXDLY)
                                | (s_q.st == mcrb_pkg::ST_CCA);
        st0[mcrb_pkg::S0_SEND]  = (s_q.st == mcrb_pkg::ST_SEND);
        st0[mcrb_pkg::S0_TURN]  = (s_q.st == mcrb_pkg::ST_TURN);
        st1 = mcrb_pkg::RST_STATE1;
        st1[mcrb_pkg::S1_CCA]  = s_q.cca_s;
        st1[mcrb_pkg::S1_LOCK] = s_q.lock_s;
    end

    assign wr_hit  = gen_find_f(mem_addr);
    assign rd_hit  = wr_hit;
    assign wr_cmd0 = mem_wr_en && (mem_addr == mcrb_pkg::A_CMD0);
    assign rd_clr  = mem_rd_en && ((mem_addr == mcrb_pkg::A_IRQ_PEND)
                                || (mem_addr == mcrb_pkg::A_IRQ_IDX));
    assign tx_busy = (s_q.st == mcrb_pkg::ST_TXDLY)
                   | (s_q.st == mcrb_pkg::ST_CCA)
                   | (s_q.st == mcrb_pkg::ST_SEND);

    always_comb begin
        s_d = s_q;
        ev  = '0;
        ev[mcrb_pkg::IRQ_RX_END]   = rx_end_evt;
        ev[mcrb_pkg::IRQ_RX_START] = rx_start_evt;
        // pins only reach logic through the second stage
        s_d.cca_m  = cca_idle;
        s_d.cca_s  = s_q.cca_m;
        s_d.lock_m = rf_locked;
        s_d.lock_s = s_q.lock_m;
        s_d.abort  = 1'b0;
        if (s_q.cnt != 8'h00) begin
            s_d.cnt = s_q.cnt - 8'h01;
        end
        // requests are acted on one cycle after the write lands
        if (!s_q.cmd0[mcrb_pkg::B_OFF]) begin
            s_d.st = mcrb_pkg::ST_OFF;
            s_d.cmd0[mcrb_pkg::B_OFF]   = 1'b1;
            s_d.cmd0[mcrb_pkg::B_ON]    = 1'b1;
            s_d.cmd0[mcrb_pkg::B_STOP]  = 1'b1;
            s_d.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST] = 1'b1;
            s_d.abort = tx_busy;
            s_d.cnt   = 8'h00;
        end else begin
            unique case (s_q.st)
                mcrb_pkg::ST_OFF: begin
                    // tx requests are dropped while powered down
                    s_d.cmd0[mcrb_pkg::B_STOP]  = 1'b1;
                    s_d.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST] = 1'b1;
                    if (!s_q.cmd0[mcrb_pkg::B_ON]) begin
                        s_d.st = mcrb_pkg::ST_WAKE;
                    end
                end
                mcrb_pkg::ST_WAKE: begin
                    s_d.cmd0[mcrb_pkg::B_STOP] = 1'b1;
                    if (s_q.lock_s) begin
                        s_d.st = mcrb_pkg::ST_READY;
                        s_d.cmd0[mcrb_pkg::B_ON] = 1'b1;
                        ev[mcrb_pkg::IRQ_READY]  = 1'b1;
                    end
                end
                mcrb_pkg::ST_READY: begin
                    s_d.cmd0[mcrb_pkg::B_ON]   = 1'b1;
                    s_d.cmd0[mcrb_pkg::B_STOP] = 1'b1;
                    if (!s_q.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST]) begin
                        s_d.st  = mcrb_pkg::ST_TXDLY;
                        s_d.cnt = mcrb_pkg::TX_READY_CNT;
                    end
                end
                mcrb_pkg::ST_TXDLY, mcrb_pkg::ST_CCA,
                mcrb_pkg::ST_SEND: begin
                    s_d.cmd0[mcrb_pkg::B_ON] = 1'b1;
                    if (!s_q.cmd0[mcrb_pkg::B_STOP]) begin
                        s_d.st    = mcrb_pkg::ST_TURN;
                        s_d.cnt   = mcrb_pkg::RX_READY_CNT;
                        s_d.abort = 1'b1;
                        s_d.cmd0[mcrb_pkg::B_STOP]  = 1'b1;
                        s_d.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST] = 1'b1;
                    end else if (s_q.st == mcrb_pkg::ST_TXDLY) begin
                        if (s_q.cnt == 8'h01) begin
                            s_d.st = mcrb_pkg::ST_CCA;
                        end
                    end else if (s_q.st == mcrb_pkg::ST_CCA) begin
                        // busy channel defers, no retry limit
                        if (s_q.cca_s) begin
                            s_d.st = mcrb_pkg::ST_SEND;
                        end
                    end else if (tx_done) begin
                        s_d.st  = mcrb_pkg::ST_TURN;
                        s_d.cnt = mcrb_pkg::RX_READY_CNT;
                        s_d.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST] = 1'b1;
                        ev[mcrb_pkg::IRQ_TX_END]    = 1'b1;
                    end
                end
                mcrb_pkg::ST_TURN: begin
                    s_d.cmd0[mcrb_pkg::B_ON]   = 1'b1;
                    s_d.cmd0[mcrb_pkg::B_STOP] = 1'b1;
                    if (s_q.cnt == 8'h01) begin
                        s_d.st = mcrb_pkg::ST_READY;
                    end
                end
                default: begin
                    s_d.st = mcrb_pkg::ST_OFF;
                end
            endcase
        end
        // cpu writes come last so a fresh request is never lost
        if (wr_cmd0) begin
            s_d.cmd0 = (s_d.cmd0 & ~mcrb_pkg::CMD0_RW_MASK)
                     | (mem_wdata & mcrb_pkg::CMD0_RW_MASK)
                     | mcrb_pkg::CMD0_RSVD_MASK;
            for (int b = 2; b < 8; b++) begin
                if ((b == mcrb_pkg::B_OFF || b == mcrb_pkg::B_ON
                     || b == mcrb_pkg::B_STOP || b == mcrb_pkg::B_TRANSMIT_REQUEST)
                    && !mem_wdata[b]) begin
                    s_d.cmd0[b] = 1'b0;
                end
            end
        end
        if (mem_wr_en && (mem_addr == mcrb_pkg::A_IRQ_EN)) begin
            s_d.irq_en = mem_wdata;
        end
        if (mem_wr_en && wr_hit[6]) begin
            s_d.gen[wr_hit[5:0]] = mem_wdata;
        end
        // read clears everything, a same-cycle event still lands
        if (rd_clr) begin
            s_d.pend_n = '1;
        end
        s_d.pend_n = s_d.pend_n & ~ev;
        s_d.irq = |(~s_d.pend_n & ~s_d.irq_en[mcrb_pkg::NIRQ-1:0]);
        if (mem_rd_en) begin
            s_d.rdata = mcrb_pkg::RD_UNMAPPED;
            if (rd_hit[6]) begin
                s_d.rdata = s_q.gen[rd_hit[5:0]];
            end
            unique case (mem_addr)
                mcrb_pkg::A_CMD0:     s_d.rdata = s_q.cmd0;
                mcrb_pkg::A_STATE0:   s_d.rdata = st0;
                mcrb_pkg::A_STATE1:   s_d.rdata = st1;
                mcrb_pkg::A_GAIN0:    s_d.rdata = mcrb_pkg::RST_GAIN0;
                mcrb_pkg::A_GAIN1:    s_d.rdata = mcrb_pkg::RST_GAIN1;
                mcrb_pkg::A_GAIN2:    s_d.rdata = mcrb_pkg::RST_GAIN2;
                mcrb_pkg::A_GAIN3:    s_d.rdata = mcrb_pkg::RST_GAIN3;
                mcrb_pkg::A_IRQ_EN:   s_d.rdata = s_q.irq_en;
                mcrb_pkg::A_IRQ_IDX:  s_d.rdata = index_f(s_q.pend_n,
                                                          s_q.irq_en);
                mcrb_pkg::A_IRQ_PEND: s_d.rdata = {4'hF, s_q.pend_n};
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= RST_S;
        end else begin
            s_q <= s_d;
        end
    end

    assign mem_rdata   = s_q.rdata;
    assign rf_power_en = (s_q.st != mcrb_pkg::ST_OFF);
    assign modem_rst_n = (s_q.st != mcrb_pkg::ST_OFF);
    assign rx_ready    = (s_q.st == mcrb_pkg::ST_READY);
    assign tx_active   = (s_q.st == mcrb_pkg::ST_SEND);
    assign tx_abort    = s_q.abort;
    assign modem_irq   = s_q.irq;

    // checks
    localparam int TXD = mcrb_pkg::TX_READY_CYC;
    localparam logic [15:0] A_PROBE = 16'h2202;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_off_seen;
        $fell(s_q.cmd0[mcrb_pkg::B_OFF])
        && !(wr_cmd0 && !mem_wdata[mcrb_pkg::B_OFF]);
    endsequence
    sequence s_tx_go;
        s_q.st == mcrb_pkg::ST_READY && !s_q.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST]
        && s_q.cmd0[mcrb_pkg::B_OFF];
    endsequence
    sequence s_wake_done;
        s_q.st == mcrb_pkg::ST_WAKE && s_q.lock_s
        && s_q.cmd0[mcrb_pkg::B_OFF];
    endsequence
    sequence s_wr_rd;
        mem_wr_en && mem_addr == A_PROBE ##1 !mem_wr_en
        ##1 mem_rd_en && !mem_wr_en && mem_addr == A_PROBE;
    endsequence

    property p_off;
        s_off_seen |=> s_q.st == mcrb_pkg::ST_OFF && !rf_power_en
                       && s_q.cmd0[mcrb_pkg::B_OFF];
    endproperty
    a_off: assert property (p_off) else $error("off request ignored");
    property p_on;
        s_q.st == mcrb_pkg::ST_OFF && !s_q.cmd0[mcrb_pkg::B_ON]
        && s_q.cmd0[mcrb_pkg::B_OFF] |=> s_q.st == mcrb_pkg::ST_WAKE;
    endproperty
    a_on: assert property (p_on) else $error("on request ignored");
    property p_ready;
        s_wake_done ##0 !wr_cmd0 |=> rx_ready && s_q.cmd0[mcrb_pkg::B_ON]
                                     && !s_q.pend_n[mcrb_pkg::IRQ_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("ready step wrong");
    property p_txdly;
        s_tx_go ##1 s_q.st == mcrb_pkg::ST_TXDLY
        |-> ##TXD (s_q.st inside {mcrb_pkg::ST_CCA, mcrb_pkg::ST_TURN,
                                  mcrb_pkg::ST_OFF});
    endproperty
    a_txdly: assert property (p_txdly) else $error("tx delay wrong");
    property p_cca;
        s_q.st == mcrb_pkg::ST_CCA && !s_q.cca_s |=> !tx_active;
    endproperty
    a_cca: assert property (p_cca) else $error("sent on busy channel");
    property p_done;
        tx_active && tx_done && s_q.cmd0[mcrb_pkg::B_STOP]
        && s_q.cmd0[mcrb_pkg::B_OFF] && !wr_cmd0
        |=> s_q.cmd0[mcrb_pkg::B_TRANSMIT_REQUEST] && s_q.st == mcrb_pkg::ST_TURN;
    endproperty
    a_done: assert property (p_done) else $error("tx done not seen");
    property p_stop;
        tx_busy && !s_q.cmd0[mcrb_pkg::B_STOP] && s_q.cmd0[mcrb_pkg::B_OFF]
        |=> tx_abort && s_q.st == mcrb_pkg::ST_TURN;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_clear;
        rd_clr && ev == '0 |=> s_q.pend_n == '1;
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear");
    property p_mask;
        s_q.irq_en[mcrb_pkg::NIRQ-1:0] == 4'hF && !mem_wr_en |=> !modem_irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq seen");
    property p_rw;
        s_wr_rd |=> mem_rdata == $past(mem_wdata, 3);
    endproperty
    a_rw: assert property (p_rw) else $error("readback mismatch");
    property p_ones;
        wr_cmd0 && mem_wdata == 8'hFF && s_q.st == mcrb_pkg::ST_READY
        && s_q.cmd0 == mcrb_pkg::RST_CMD0 |=> s_q.st == mcrb_pkg::ST_READY;
    endproperty
    a_ones: assert property (p_ones) else $error("one write acted");

endmodule : mcrb_bank

//--- mcrb_pkg.sv
// constants, types and register table of the modem command register bank
// assumes one 100 MHz clock and 8-bit data memory accesses from the cpu
package mcrb_pkg;

    // timing
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned TX_READY_DELAY_NS = 1920;
    localparam int unsigned RX_READY_DELAY_NS = 1920;
    localparam int unsigned TX_READY_CYC      =
        (TX_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RX_READY_CYC      =
        (RX_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  TX_READY_CNT      = 8'(TX_READY_CYC);
    localparam logic [7:0]  RX_READY_CNT      = 8'(RX_READY_CYC);

    // registers with their own logic
    localparam logic [15:0] A_CMD0     = 16'h2200;
    localparam logic [15:0] A_STATE0   = 16'h2270;
    localparam logic [15:0] A_STATE1   = 16'h2271;
    localparam logic [15:0] A_GAIN0    = 16'h2272;
    localparam logic [15:0] A_GAIN1    = 16'h2273;
    localparam logic [15:0] A_GAIN2    = 16'h2274;
    localparam logic [15:0] A_GAIN3    = 16'h2275;
    localparam logic [15:0] A_IRQ_EN   = 16'h2277;
    localparam logic [15:0] A_IRQ_IDX  = 16'h2278;
    localparam logic [15:0] A_IRQ_PEND = 16'h227E;

    localparam logic [7:0]  RST_CMD0     = 8'hFC;
    localparam logic [7:0]  RST_STATE0   = 8'h80;
    localparam logic [7:0]  RST_STATE1   = 8'hF0;
    localparam logic [7:0]  RST_GAIN0    = 8'hFF;
    localparam logic [7:0]  RST_GAIN1    = 8'hDF;
    localparam logic [7:0]  RST_GAIN2    = 8'h00;
    localparam logic [7:0]  RST_GAIN3    = 8'h00;
    localparam logic [7:0]  RST_IRQ_EN   = 8'hF0;
    localparam logic [7:0]  RST_IRQ_PEND = 8'hFF;
    localparam logic [7:0]  RD_UNMAPPED  = 8'h00;

    // modem_command_0 fields, requests act on a written zero
    localparam int B_OFF   = 7;
    localparam int B_ON    = 6;
    localparam int B_STOP  = 3;
    localparam int B_TRANSMIT_REQUEST = 2;
    localparam logic [7:0] CMD0_RSVD_MASK = 8'h30;
    localparam logic [7:0] CMD0_RW_MASK   = 8'h03;

    // irq sources, pending bits are active low
    localparam int NIRQ         = 4;
    localparam int IRQ_RX_END   = 0;
    localparam int IRQ_RX_START = 1;
    localparam int IRQ_TX_END   = 2;
    localparam int IRQ_READY    = 3;
    localparam logic [4:0] IDX_FILL = 5'h1F;

    // modem_state_0 / modem_state_1 fields
    localparam int S0_OFF   = 7;
    localparam int S0_READY = 0;
    localparam int S0_TXDLY = 1;
    localparam int S0_SEND  = 2;
    localparam int S0_TURN  = 3;
    localparam int S1_CCA   = 0;
    localparam int S1_LOCK  = 1;

    // plain read/write registers
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  rst;
    } mcrb_gen_t;

    localparam int NGEN = 34;
    localparam mcrb_gen_t GEN_TAB [NGEN] = '{
        '{16'h2201, 8'hC7}, '{16'h2202, 8'hE0}, '{16'h2203, 8'hFF},
        '{16'h2204, 8'h00}, '{16'h2205, 8'hFF}, '{16'h2206, 8'hD0},
        '{16'h2207, 8'hFF}, '{16'h220D, 8'h00}, '{16'h2211, 8'h02},
        '{16'h2212, 8'hA7}, '{16'h2213, 8'h4F}, '{16'h2215, 8'hF2},
        '{16'h2217, 8'h63}, '{16'h2223, 8'h7F}, '{16'h2248, 8'hC0},
        '{16'h2249, 8'hB2}, '{16'h224A, 8'h01}, '{16'h224B, 8'hF4},
        '{16'h2260, 8'h40}, '{16'h2261, 8'h6C}, '{16'h2262, 8'hFF},
        '{16'h2263, 8'h0F}, '{16'h226D, 8'h00}, '{16'h226E, 8'h40},
        '{16'h2279, 8'h90}, '{16'h2286, 8'h38}, '{16'h2287, 8'h40},
        '{16'h2288, 8'h00}, '{16'h2289, 8'h2F}, '{16'h228A, 8'h14},
        '{16'h228B, 8'h32}, '{16'h22A0, 8'h18}, '{16'h22A1, 8'hF8},
        '{16'h22A2, 8'h96}
    };

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_WAKE  = 3'b001,
        ST_READY = 3'b011,
        ST_TXDLY = 3'b010,
        ST_CCA   = 3'b110,
        ST_SEND  = 3'b111,
        ST_TURN  = 3'b101
    } mcrb_state_t;

endpackage : mcrb_pkg

//--- mcrb_radio_model.sv
// rf and modem far side of the command register bank
// assumes the bank's state outputs and the bench's busy and kick knobs
module mcrb_radio_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic rf_power_en,
    input  wire logic tx_active,
    input  wire logic chan_busy,
    input  wire logic rx_kick,
    output logic      rf_locked,
    output logic      cca_idle,
    output logic      tx_done,
    output logic      rx_start_evt,
    output logic      rx_end_evt
);
    logic [4:0] lock_cnt;
    logic [5:0] tx_cnt;

    // lock is lost at once on power down, so a fresh on must wait again
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt     <= 5'h00;
            tx_cnt       <= 6'h00;
            rx_start_evt <= 1'b0;
            rx_end_evt   <= 1'b0;
        end else begin
            if (!rf_power_en)
                lock_cnt <= 5'h00;
            else if (lock_cnt != 5'h14)
                lock_cnt <= lock_cnt + 5'h01;
            tx_cnt       <= tx_active ? tx_cnt + 6'h01 : 6'h00;
            rx_start_evt <= rx_kick;
            rx_end_evt   <= rx_start_evt;
        end
    end

    assign rf_locked = (lock_cnt == 5'h14);
    assign tx_done   = (tx_cnt == 6'h1E);
    assign cca_idle  = !chan_busy;
endmodule : mcrb_radio_model

//--- test_modem_command_register_bank.sv
// self-checking bench of the command register bank
// assumes mcrb_radio_model on the rf side, cpu strobes driven here
module test_modem_command_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, arst_n, wr_en, rd_en, chan_busy, rx_kick;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    logic        rf_locked, cca_idle, rx_start_evt, rx_end_evt, tx_done;
    logic        rf_power_en, modem_rst_n, rx_ready, tx_active;
    logic        tx_abort, modem_irq;
    logic [2:0]  mon;
    int          num_errors, checked;

    assign mon = {tx_abort, tx_active, rx_ready};

    mcrb_bank dut_u (.clk(clk), .arst_n(arst_n), .mem_wr_en(wr_en),
        .mem_rd_en(rd_en), .mem_addr(addr), .mem_wdata(wdata),
        .mem_rdata(rdata), .cca_idle(cca_idle), .rf_locked(rf_locked),
        .rx_start_evt(rx_start_evt), .rx_end_evt(rx_end_evt),
        .tx_done(tx_done), .rf_power_en(rf_power_en),
        .modem_rst_n(modem_rst_n), .rx_ready(rx_ready),
        .tx_active(tx_active), .tx_abort(tx_abort), .modem_irq(modem_irq));

    mcrb_radio_model radio_u (.clk(clk), .arst_n(arst_n),
        .rf_power_en(rf_power_en), .tx_active(tx_active),
        .chan_busy(chan_busy), .rx_kick(rx_kick), .rf_locked(rf_locked),
        .cca_idle(cca_idle), .tx_done(tx_done),
        .rx_start_evt(rx_start_evt), .rx_end_evt(rx_end_evt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task complete_run;
        $display("errors %0d checked %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
    endtask : wr

    task rchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr  = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        chk(rdata, exp, "read");
    endtask : rchk

    // bounded wait on one monitored flag, a hang ends the run
    task wait_on(input int b, input int lim);
        int n;
        n = 0;
        while (mon[b] !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (mon[b] !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t wait timed out", $time);
            complete_run();
        end
    endtask : wait_on

    task kick;
        @(posedge clk);
        #1;
        rx_kick = 1'b1;
        @(posedge clk);
        #1;
        rx_kick = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : kick

    task t_reset;
        for (int i = 0; i < mcrb_pkg::NGEN; i++)
            rchk(mcrb_pkg::GEN_TAB[i].addr, mcrb_pkg::GEN_TAB[i].rst);
        rchk(mcrb_pkg::A_CMD0, 8'hFC);
        rchk(mcrb_pkg::A_STATE0, 8'h80);
        rchk(mcrb_pkg::A_IRQ_EN, 8'hF0);
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFF);
        rchk(16'h2208, 8'h00);
        wr(16'h2202, 8'h5A);
        rchk(16'h2202, 8'h5A);
        // tuning value put back, software leaves it alone from here
        wr(16'h2202, 8'hE0);
        chk(8'(rf_power_en), 8'h00, "power");
        $display("done reset");
    endtask : t_reset

    task t_on;
        wr(mcrb_pkg::A_CMD0, 8'hBC);
        wait_on(0, 100);
        rchk(mcrb_pkg::A_CMD0, 8'hFC);
        chk(8'(modem_rst_n), 8'h01, "rst");
        chk(8'(modem_irq), 8'h01, "irq");
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hF7);
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFF);
        chk(8'(modem_irq), 8'h00, "irq");
        $display("done on");
    endtask : t_on

    task t_tx;
        chan_busy = 1'b1;
        wr(mcrb_pkg::A_CMD0, 8'hF8);
        repeat (250) @(posedge clk);
        #1;
        chk(8'(tx_active), 8'h00, "busy");
        rchk(mcrb_pkg::A_CMD0, 8'hF8);
        chan_busy = 1'b0;
        wait_on(1, 10);
        wait_on(0, 300);
        rchk(mcrb_pkg::A_CMD0, 8'hFC);
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFB);
        $display("done tx");
    endtask : t_tx

    task t_stop;
        wr(mcrb_pkg::A_CMD0, 8'hF8);
        // tx delay is 192 cycles, so nothing may send before it runs out
        repeat (100) @(posedge clk);
        #1;
        chk(8'(tx_active), 8'h00, "early");
        wr(mcrb_pkg::A_CMD0, 8'hF4);
        wait_on(2, 210);
        rchk(mcrb_pkg::A_CMD0, 8'hFC);
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFF);
        wait_on(0, 200);
        $display("done stop");
    endtask : t_stop

    task t_irq;
        wr(mcrb_pkg::A_IRQ_EN, 8'hFF);
        kick();
        chk(8'(modem_irq), 8'h00, "masked");
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFC);
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFF);
        wr(mcrb_pkg::A_IRQ_EN, 8'hF0);
        kick();
        chk(8'(modem_irq), 8'h01, "irq");
        rchk(mcrb_pkg::A_IRQ_IDX, 8'h7C);
        rchk(mcrb_pkg::A_IRQ_PEND, 8'hFF);
        $display("done irq");
    endtask : t_irq

    task t_off;
        wr(mcrb_pkg::A_CMD0, 8'hFF);
        rchk(mcrb_pkg::A_CMD0, 8'hFF);
        chk(8'(rx_ready), 8'h01, "ready");
        wr(mcrb_pkg::A_CMD0, 8'h7F);
        rchk(mcrb_pkg::A_CMD0, 8'hFF);
        chk(8'(rf_power_en), 8'h00, "power");
        chk(8'(modem_rst_n), 8'h00, "rst");
        rchk(mcrb_pkg::A_STATE0, 8'h80);
        $display("done off");
    endtask : t_off

    initial begin
        num_errors = 0;
        checked    = 0;
        arst_n     = 1'b0;
        wr_en      = 1'b0;
        rd_en      = 1'b0;
        addr       = 16'h0000;
        wdata      = 8'h00;
        chan_busy  = 1'b0;
        rx_kick    = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_on();
        t_tx();
        t_stop();
        t_irq();
        t_off();
        complete_run();
    end
endmodule : test_modem_command_register_bank
